/* shared/remote_image_upgrade_regs.vh */
`ifndef REMOTE_IMAGE_UPGRADE_REGS_VH
`define REMOTE_IMAGE_UPGRADE_REGS_VH
// ****************************************************************
// Register offsets (plain port bus, word addressed)
// ****************************************************************
`define RIU_ADDR_W 4
`define RIU_OFS_CTRL 4'h0
`define RIU_OFS_UPDATE 4'h1
`define RIU_OFS_STATUS 4'h2
`define RIU_OFS_BOOT 4'h3
`define RIU_OFS_CMD 4'h4
`define RIU_OFS_FACTORY 4'h5
`define RIU_OFS_SHIFT 4'h6
// ****************************************************************
// Field layouts
// ****************************************************************
`define RIU_ADDR_FIELD_W 22
`define RIU_WD_FIELD_W 12
`define RIU_CTRL_WD_EN_BIT 22
`define RIU_CTRL_WD_LSB 23
`define RIU_CMD_RECONFIG_BIT 0
`define RIU_CMD_WD_RESTART_BIT 1
`define RIU_CMD_CAPTURE_BIT 2
`define RIU_CMD_UPDATE_BIT 3
`define RIU_ST_PIN_BIT 0
`define RIU_ST_CRC_BIT 1
`define RIU_ST_WD_BIT 2
`define RIU_ST_RESET_BIT 3
`define RIU_ST_APP_BIT 4
`define RIU_ST_BUSY_BIT 5
// ****************************************************************
// Reset values and fixed patterns
// ****************************************************************
`define RIU_SERIAL_FACTORY_ADDR 24'h000000
`define RIU_PARALLEL_FACTORY_ADDR 24'h010000
`define RIU_WD_LOW_PATTERN 17'h00008
`define RIU_WD_COUNT_W 29
// ****************************************************************
// Timing
// ****************************************************************
`define RIU_CLK_MHZ 20
`define RIU_LOAD_TIME_US 10
`define RIU_LOAD_CYCLES (`RIU_LOAD_TIME_US * `RIU_CLK_MHZ)
`endif

/* verilog/watchdog_counter.v */
`include "remote_image_upgrade_regs.vh"
module watchdog_counter #(
  parameter CW = `RIU_WD_COUNT_W
) (
  // Clock and control
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Watchdog control
  input wire run_i,
  input wire restart_i,
  input wire [`RIU_WD_FIELD_W-1:0] timeout_i,
  // Expiry pulse
  output reg expired_o
);
  reg [CW-1:0] count_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= {CW{1'b0}};
      expired_o <= 1'b0;
    end else if (ce_i) begin
      expired_o <= 1'b0;
      if (!run_i || restart_i) begin
        count_q <= {timeout_i, `RIU_WD_LOW_PATTERN}; // see (RULE17)
      end else if (count_q == {CW{1'b0}}) begin
        expired_o <= 1'b1; // see (RULE13)
        count_q <= {timeout_i, `RIU_WD_LOW_PATTERN};
      end else begin
        count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // watchdog_counter

/* verilog/upgrade_shift_path.v */
`include "remote_image_upgrade_regs.vh"
module upgrade_shift_path #(
  parameter W = 32
) (
  // Clock and control
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Shift register access
  input wire capture_i,
  input wire [W-1:0] capture_data_i,
  input wire load_i,
  input wire [W-1:0] load_data_i,
  input wire write_allowed_i,
  input wire update_i,
  // Results
  output reg [W-1:0] shift_o,
  output reg [W-1:0] update_o
);
  // The shift path follows the upgrade_shift_clock; here it is one domain.
  always @(posedge clk_i) begin
    if (rst_i) begin
      shift_o <= {W{1'b0}};
      update_o <= {W{1'b0}};
    end else if (ce_i) begin
      if (capture_i) begin
        shift_o <= capture_data_i;
      end else if (load_i && write_allowed_i) begin
        shift_o <= load_data_i; // see (RULE19)
      end
      if (update_i && write_allowed_i) begin
        update_o <= shift_o; // see (RULE19)
      end
    end
  end
endmodule // upgrade_shift_path

/* verilog/remote_image_upgrade.v */
`include "remote_image_upgrade_regs.vh"
// How it works
// (RULE1) Serial scheme boots factory from zero.
// (RULE2) Parallel scheme boots factory at 0x010000.
// (RULE3) JTAG instruction replaces parallel factory address.
// (RULE4) Parallel factory address counts 16-bit words.
// (RULE5) Every reconfiguration cause writes status register.
// (RULE6) Errors reload factory image automatically.
// (RULE7) Factory logic writes address, watchdog enable, timeout.
// (RULE8) Factory reads cause, picks image, triggers.
// (RULE9) Clean application load enters user mode.
// (RULE10) Application stores update then reloads factory.
// (RULE11) Healthy application restarts watchdog periodically.
// (RULE12) Application may start on any sector.
// (RULE13) Watchdog expiry is a reconfiguration cause.
// (RULE14) Standard mode keeps upgrade circuitry disabled.
// (RULE15) Security variant allows serial scheme only.
// (RULE16) Boot address is field plus two zeros.
// (RULE17) Watchdog count is field plus 17'b1000.
// (RULE18) Registers on oscillator, shift on user clock; here both run on clk_i.
// (RULE19) Update writes only while factory runs.
// (RULE20) Status holds one flag per cause.
// (RULE21) Fabric reset request reconfigures from control address.
module remote_image_upgrade #(
  parameter SECURE_VARIANT = 0,
  parameter LOAD_CYCLES = `RIU_LOAD_CYCLES
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Straps
  input wire upgrade_enable_i,
  input wire parallel_scheme_i,
  // Register port
  input wire [`RIU_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Reconfiguration causes and JTAG factory address
  input wire config_status_pin_low_i,
  input wire crc_error_i,
  input wire config_reset_request_i,
  input wire factory_address_jtag_instruction_i,
  input wire [23:0] jtag_factory_addr_i,
  // Configuration memory loader
  input wire load_error_i,
  output reg [23:0] boot_addr_o,
  output reg load_start_o,
  output reg user_mode_o,
  output reg factory_running_o
);
  // ****************************************************************
  // States
  // ****************************************************************
  localparam S_IDLE = 4'b0001;
  localparam S_LOAD = 4'b0010;
  localparam S_USER = 4'b0100;
  localparam S_OFF = 4'b1000;
  localparam CNT_W = 16;
  localparam [CNT_W-1:0] LOAD_LAST = LOAD_CYCLES - 1;

  function is_wr;
    input [`RIU_ADDR_W-1:0] a;
    input [`RIU_ADDR_W-1:0] ofs;
    begin
      is_wr = wr_i && (a == ofs);
    end
  endfunction

  reg [3:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  reg [31:0] ctrl_q;
  reg [5:0] status_q;
  reg [23:0] factory_addr_q;
  reg app_q;
  reg target_app_q;
  reg reset_req_q;
  reg wd_restart_q;
  wire wd_expired;
  wire [31:0] shift_val;
  wire [31:0] update_val;
  wire enabled;
  wire scheme_ok;
  wire [3:0] cause;
  wire any_cause;
  wire reset_rise;

  // A security variant refuses the parallel scheme outright.
  assign scheme_ok = !(SECURE_VARIANT != 0 && parallel_scheme_i); // see (RULE15)
  assign enabled = upgrade_enable_i && scheme_ok; // see (RULE14)
  assign reset_rise = config_reset_request_i && !reset_req_q;
  assign cause = {reset_rise, wd_expired, crc_error_i, config_status_pin_low_i};
  assign any_cause = |cause && (state_q == S_USER || state_q == S_LOAD);

  // ****************************************************************
  // Sub blocks
  // ****************************************************************
  watchdog_counter #(.CW(`RIU_WD_COUNT_W)) u_wd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(state_q == S_USER && app_q && ctrl_q[`RIU_CTRL_WD_EN_BIT]),
    .restart_i(wd_restart_q), // see (RULE11)
    .timeout_i({3'b000, ctrl_q[31:`RIU_CTRL_WD_LSB]}),
    .expired_o(wd_expired)
  );

  upgrade_shift_path #(.W(32)) u_shift (
    .clk_i(clk_i), // see (RULE18)
    .rst_i(rst_i),
    .ce_i(ce_i),
    .capture_i(is_wr(addr_i, `RIU_OFS_CMD) && wdata_i[`RIU_CMD_CAPTURE_BIT]),
    .capture_data_i(app_q ? ctrl_q : update_val),
    .load_i(is_wr(addr_i, `RIU_OFS_SHIFT)),
    .load_data_i(wdata_i),
    .write_allowed_i(enabled && !app_q && state_q == S_USER), // see (RULE19)
    .update_i(is_wr(addr_i, `RIU_OFS_CMD) && wdata_i[`RIU_CMD_UPDATE_BIT]),
    .shift_o(shift_val),
    .update_o(update_val)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      cnt_q <= {CNT_W{1'b0}};
      ctrl_q <= 32'h00000000;
      status_q <= 6'h00;
      factory_addr_q <= `RIU_PARALLEL_FACTORY_ADDR;
      app_q <= 1'b0;
      target_app_q <= 1'b0;
      reset_req_q <= 1'b0;
      wd_restart_q <= 1'b0;
      boot_addr_o <= 24'h000000;
      load_start_o <= 1'b0;
      user_mode_o <= 1'b0;
      factory_running_o <= 1'b0;
      rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      load_start_o <= 1'b0;
      reset_req_q <= config_reset_request_i;
      wd_restart_q <= is_wr(addr_i, `RIU_OFS_CMD) && wdata_i[`RIU_CMD_WD_RESTART_BIT];
      if (factory_address_jtag_instruction_i && parallel_scheme_i) begin
        factory_addr_q <= jtag_factory_addr_i; // see (RULE3) (RULE4)
      end
      // Factory logic programs the next image; application sees it read-only.
      if (is_wr(addr_i, `RIU_OFS_CTRL) && !app_q && state_q == S_USER) begin
        ctrl_q <= wdata_i; // see (RULE7)
      end
      case (state_q)
        S_IDLE: begin
          if (!enabled) begin
            state_q <= S_OFF; // see (RULE14)
          end else begin
            // Power-up: factory image, serial at zero, parallel at default.
            boot_addr_o <= parallel_scheme_i ? factory_addr_q
                                             : `RIU_SERIAL_FACTORY_ADDR; // see (RULE1) (RULE2)
            target_app_q <= 1'b0;
            load_start_o <= 1'b1;
            cnt_q <= {CNT_W{1'b0}};
            state_q <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (load_error_i || any_cause) begin
            status_q[3:0] <= cause | {3'b000, load_error_i}; // see (RULE5) (RULE20)
            boot_addr_o <= parallel_scheme_i ? factory_addr_q
                                             : `RIU_SERIAL_FACTORY_ADDR; // see (RULE6)
            target_app_q <= 1'b0;
            load_start_o <= 1'b1;
            cnt_q <= {CNT_W{1'b0}};
          end else if (cnt_q == LOAD_LAST) begin
            app_q <= target_app_q;
            user_mode_o <= 1'b1; // see (RULE9)
            factory_running_o <= !target_app_q;
            state_q <= S_USER;
          end else begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        S_USER: begin
          if (any_cause) begin
            status_q[3:0] <= cause; // see (RULE5) (RULE20)
            status_q[`RIU_ST_APP_BIT] <= app_q;
            user_mode_o <= 1'b0;
            factory_running_o <= 1'b0;
            cnt_q <= {CNT_W{1'b0}};
            load_start_o <= 1'b1;
            state_q <= S_LOAD;
            if (reset_rise && !app_q) begin
              // Factory trigger: update contents move to control.
              ctrl_q <= update_val;
              boot_addr_o <= {update_val[`RIU_ADDR_FIELD_W-1:0], 2'b00}; // see (RULE16) (RULE21)
              target_app_q <= 1'b1; // see (RULE12)
            end else begin
              boot_addr_o <= parallel_scheme_i ? factory_addr_q
                                               : `RIU_SERIAL_FACTORY_ADDR; // see (RULE6) (RULE10)
              target_app_q <= 1'b0;
            end
          end
        end
        S_OFF: begin
          user_mode_o <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      status_q[`RIU_ST_BUSY_BIT] <= (state_q == S_LOAD);
      if (rd_i) begin
        case (addr_i)
          `RIU_OFS_CTRL: rdata_o <= ctrl_q;
          `RIU_OFS_UPDATE: rdata_o <= update_val;
          `RIU_OFS_STATUS: rdata_o <= {26'h0000000, status_q}; // see (RULE8)
          `RIU_OFS_BOOT: rdata_o <= {8'h00, boot_addr_o};
          `RIU_OFS_FACTORY: rdata_o <= {8'h00, factory_addr_q};
          `RIU_OFS_SHIFT: rdata_o <= shift_val;
          default: rdata_o <= 32'h00000000;
        endcase
      end else begin
        rdata_o <= 32'h00000000;
      end
    end
  end
endmodule // remote_image_upgrade

/* test/remote_image_upgrade_assertions.sv */
module remote_image_upgrade_assertions #(
  parameter LOAD_CYCLES = 4,
  parameter SECURE_VARIANT = 0
) (
  // Clock and straps
  input logic clk_i,
  input logic rst_i,
  input logic upgrade_enable_i,
  input logic parallel_scheme_i,
  // Causes and register port
  input logic crc_error_i,
  input logic rd_i,
  input logic [3:0] addr_i,
  input logic [31:0] rdata_o,
  // Loader side
  input logic [23:0] boot_addr_o,
  input logic load_start_o,
  input logic user_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q;
  always @(posedge clk_i) cnt_q <= (rst_i || load_start_o) ? 0 : cnt_q + 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    ##1 load_start_o;
  endsequence
  a_serial_boot: assert property (
    $fell(rst_i) && !parallel_scheme_i |-> s_start ##0 boot_addr_o == 24'h000000)
    else $error("serial factory address wrong");
  a_parallel_boot: assert property (
    $fell(rst_i) && parallel_scheme_i && SECURE_VARIANT == 0 |-> s_start ##0
    boot_addr_o == 24'h010000) else $error("parallel factory address wrong");
  a_crc_reload: assert property (
    crc_error_i && user_mode_o && upgrade_enable_i && !parallel_scheme_i |-> s_start ##0
    boot_addr_o == 24'h000000) else $error("no factory reload on crc");
  a_start_pulse: assert property (load_start_o |=> !load_start_o)
    else $error("load start longer than one cycle");
  a_start_leaves_user: assert property (load_start_o |-> !user_mode_o)
    else $error("user mode during load");
  a_load_time: assert property (
    $rose(user_mode_o) |-> cnt_q >= LOAD_CYCLES - 1 && cnt_q <= LOAD_CYCLES + 1)
    else $error("user mode at wrong time");
  a_boot_aligned: assert property (load_start_o |-> boot_addr_o[1:0] == 2'b00)
    else $error("boot address not aligned");
  a_boot_hold: assert property ($changed(boot_addr_o) |-> load_start_o)
    else $error("boot address moved outside a load");
  a_unmapped_zero: assert property (
    rd_i && addr_i > 4'h6 |=> rdata_o == 32'h00000000) else $error("unmapped read not zero");
endmodule // remote_image_upgrade_assertions

/* test/config_memory_model.sv */
module config_memory_model (
  input logic clk_i,
  input logic load_start_i,
  input logic fail_i,
  input int delay_i,
  output logic load_error_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = -1;
  initial load_error_o = 1'b0;
  // A failing image reports its error a chosen number of cycles into the load.
  always @(posedge clk_i) begin
    if (load_start_i) n <= fail_i ? delay_i : -1;
    else if (n >= 0) n <= n - 1;
    load_error_o <= (n == 0);
  end
endmodule // config_memory_model

/* test/test_remote_image_upgrade.sv */
`include "remote_image_upgrade_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module test_remote_image_upgrade;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, par = 0, pin = 0, crc = 0, req = 0, jins = 0, wr = 0, rd = 0;
  logic fail = 0, lerr, start, um, fr;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, rdata, s;
  logic [23:0] jaddr = 0, boot, fac;
  logic [23:0] exp_q[$];
  int error_cnt = 0, num_checks = 0, dly = 0;
  always #25 clk_i = ~clk_i;
  remote_image_upgrade #(.LOAD_CYCLES(8)) remote_image_upgrade_i (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .upgrade_enable_i(1'b1), .parallel_scheme_i(par), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .config_status_pin_low_i(pin),
    .crc_error_i(crc), .config_reset_request_i(req), .factory_address_jtag_instruction_i(jins),
    .jtag_factory_addr_i(jaddr), .load_error_i(lerr), .boot_addr_o(boot),
    .load_start_o(start), .user_mode_o(um), .factory_running_o(fr));
  config_memory_model config_memory_model_i (.clk_i(clk_i), .load_start_i(start),
    .fail_i(fail), .delay_i(dly), .load_error_o(lerr));
  // ********
  // Bus, cause and load helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i); addr <= a; wdata <= d; wr <= 1;
    @(posedge clk_i); wr <= 0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i); addr <= a; rd <= 1;
    @(posedge clk_i); rd <= 0;
    @(negedge clk_i); `CHK(rdata, e)
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k) 0: pin <= 1; 1: crc <= 1; 2: req <= 1; default: jins <= 1; endcase
    @(posedge clk_i); {pin, crc, req, jins} <= 4'h0;
  endtask
  task automatic run;
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (um !== 1'b1 && n < 200) begin @(posedge clk_i); n++; end
    @(negedge clk_i);
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge clk_i) if (start === 1'b1) `CHK(boot, exp_q.pop_front())
  initial begin #(50 * 4000); error_cnt++; end_of_test; end
  // ********
  // Scenarios
  // ********
  initial begin
    s = 32'h952679EA;
    fac = 24'h000000;
    exp_q.push_back(fac);
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    run;
    `CHK(fr, 1'b1)
    rdc(4'hF, 32'h00000000);
    wrt(`RIU_OFS_CTRL, 32'h00400123);
    rdc(`RIU_OFS_CTRL, 32'h00400123);
    // Each pass launches an application, then either breaks it or lets the load fail.
    for (int k = 0; k < 5; k++) begin
      fail = (k > 2);
      dly = (k == 3) ? 0 : 5;
      s = lfsr(s);
      wrt(`RIU_OFS_SHIFT, {10'h000, s[21:0]});
      wrt(`RIU_OFS_CMD, 32'h00000008);
      rdc(`RIU_OFS_UPDATE, {10'h000, s[21:0]});
      exp_q.push_back({s[21:0], 2'b00});
      if (fail) exp_q.push_back(fac);
      pulse(2);
      // Only the application load may fail; the factory fall-back must load cleanly.
      if (fail) begin
        @(posedge clk_i);
        @(negedge clk_i);
        fail = 0;
      end
      run;
      if (k < 3) begin
        `CHK(fr, 1'b0)
        wrt(`RIU_OFS_SHIFT, ~s);
        wrt(`RIU_OFS_CMD, 32'h00000008);
        rdc(`RIU_OFS_UPDATE, {10'h000, s[21:0]});
        exp_q.push_back(fac);
        pulse(k);
        run;
        rdc(`RIU_OFS_STATUS, (k == 2 ? 32'h8 : 32'h1 << k) | 32'h10);
      end
      `CHK(fr, 1'b1)
    end
    // Application with the watchdog on and the shortest time-out.
    wrt(`RIU_OFS_SHIFT, 32'h00400100);
    wrt(`RIU_OFS_CMD, 32'h00000008);
    exp_q.push_back(24'h000400);
    exp_q.push_back(fac);
    pulse(2);
    run;
    repeat (4) wrt(`RIU_OFS_CMD, 32'h00000002);
    `CHK(um, 1'b1)
    `CHK(fr, 1'b0)
    repeat (12) @(posedge clk_i);
    run;
    `CHK(fr, 1'b1)
    rdc(`RIU_OFS_STATUS, 32'h00000014);
    @(posedge clk_i); rst_i <= 1; par <= 1;
    exp_q.delete();
    fac = 24'h010000;
    exp_q.push_back(fac);
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    run;
    `CHK(fr, 1'b1)
    jaddr <= 24'h2A0000;
    pulse(3);
    fac = 24'h2A0000;
    exp_q.push_back(fac);
    pulse(1);
    run;
    `CHK(exp_q.size(), 0)
    end_of_test;
  end
endmodule // test_remote_image_upgrade
bind remote_image_upgrade remote_image_upgrade_assertions #(.LOAD_CYCLES(LOAD_CYCLES),
  .SECURE_VARIANT(SECURE_VARIANT)) chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .upgrade_enable_i(upgrade_enable_i), .parallel_scheme_i(parallel_scheme_i),
  .crc_error_i(crc_error_i), .rd_i(rd_i), .addr_i(addr_i), .rdata_o(rdata_o),
  .boot_addr_o(boot_addr_o), .load_start_o(load_start_o), .user_mode_o(user_mode_o));
